// ==== dgptc_partner.sv ====
// External signal source: count clock, gate and direction pins.
// Assumes the bench calls its tasks; the clock stands low between bursts.
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Pin source
// ****************************************
module dgptc_partner (
  // Clock
  input wire logic sys_clk,
  // Pins toward the counters
  output logic [1:0] counter_clock_in,
  output logic [1:0] counter_gate_in,
  output logic [1:0] count_direction_in
);
  // Quiet levels at time zero
  initial begin
    counter_clock_in = 2'h0;
    counter_gate_in = 2'h0;
    count_direction_in = 2'h0;
  end

  // Burst of count pulses, five cycles each, well under half sys_clk
  task automatic pulses(input int ch, input int n);
    repeat (n) begin
      @(posedge sys_clk);
      counter_clock_in[ch] <= 1'b1;
      repeat (2) @(posedge sys_clk);
      counter_clock_in[ch] <= 1'b0;
      repeat (2) @(posedge sys_clk);
    end
  endtask : pulses

  // Gate and direction levels
  task automatic pins(input int ch, input logic g, input logic d);
    @(posedge sys_clk);
    counter_gate_in[ch] <= g;
    count_direction_in[ch] <= d;
  endtask : pins
endmodule : dgptc_partner
`default_nettype wire

// ==== dgptc_pkg.sv ====
// Constants, field layouts and types for the dual timer/counter block.
// Assumes a single 20 MHz system clock and a plain strobe register port.
package dgptc_pkg;

  // ****************************************
  // Clock rates and derived counts
  // ****************************************
  localparam int unsigned SYS_CLK_HZ = 20000000; // System clock rate
  localparam int unsigned INT_CLK_HZ = 10000000; // Internal count clock rate
  localparam int unsigned EXT_CLK_MAX_HZ = 10000000; // Fastest external count clock
  localparam logic [7:0] INT_DIV_CYC = 8'(SYS_CLK_HZ / INT_CLK_HZ); // Cycles per tick

  // ****************************************
  // Register offsets (byte addresses)
  // ****************************************
  localparam logic [7:0] CH_STRIDE = 8'h20; // Channel 1 base
  localparam logic [4:0] OFF_CTRL = 5'h00; // Channel configuration
  localparam logic [4:0] OFF_CMD = 5'h04; // Start and soft reset strobes
  localparam logic [4:0] OFF_INIT = 5'h08; // Initial count
  localparam logic [4:0] OFF_DELAY = 5'h0C; // Pulse delay or interval
  localparam logic [4:0] OFF_WIDTH = 5'h10; // Pulse width
  localparam logic [4:0] OFF_COUNT = 5'h14; // Present count, read only
  localparam logic [4:0] OFF_STAT = 5'h18; // Channel state, read only
  localparam logic [7:0] OFF_IRQ_STAT = 8'h40; // Sticky events, write one to clear
  localparam logic [7:0] OFF_IRQ_MASK = 8'h44; // Event enables

  // ****************************************
  // Field positions
  // ****************************************
  localparam int CTRL_MODE_LSB = 0; // Three-bit mode select
  localparam int CTRL_CLK_SRC = 3; // 1 external pin, 0 internal clock
  localparam int CTRL_CLK_POL = 4; // 1 falling edge active
  localparam int CTRL_GATE_SRC = 5; // 1 gate pin, 0 software gate
  localparam int CTRL_GATE_POL = 6; // 1 gate active low
  localparam int CTRL_GATE_SW = 7; // Software gate level
  localparam int CTRL_DIR_SRC = 8; // 1 direction pin, 0 software
  localparam int CTRL_DIR_SW = 9; // Software direction, 1 up
  localparam int CTRL_OUT_POL = 10; // 1 output active low
  localparam int CMD_START = 0; // Software start
  localparam int CMD_RESET = 1; // Software counter reset
  localparam int STAT_OUT = 8; // Output pin level in status

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [1:0] IRQ_RST = 2'h0;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [2:0] {
    MODE_GATED_CNT = 3'h0, MODE_PERIOD = 3'h1, MODE_PWIDTH = 3'h2,
    MODE_GATED_PULSE = 3'h3, MODE_TRIG_PULSE = 3'h4, MODE_RETRIG = 3'h5,
    MODE_TRIG_CONT = 3'h6, MODE_GATED_CONT = 3'h7
  } dgptc_mode_t;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01, ST_ARM = 6'h02, ST_RUN = 6'h04,
    ST_DELAY = 6'h08, ST_PULSE = 6'h10, ST_DONE = 6'h20
  } dgptc_state_t;

endpackage : dgptc_pkg

// ==== dgptc_sva.sv ====
// Port checker for the dual timer/counter top.
// Assumes one clock sys_clk and channel bases 0x00 and 0x20.
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Checker
// ****************************************
module dgptc_sva (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [31:0] reg_rdata,
  // Pins and interrupt
  input wire logic [1:0] counter_clock_in,
  input wire logic [1:0] counter_gate_in,
  input wire logic [1:0] count_direction_in,
  input wire logic [1:0] counter_output,
  input wire logic irq
);
  // Shadow of start, polarity and mask writes
  typedef struct packed {
    logic [1:0] run; // Channel started
    logic [1:0] pol; // Output polarity
    logic [1:0] mask; // Interrupt enables
    logic [1:0][2:0] age; // Cycles since last control or command write
  } dgptc_chk_t;
  dgptc_chk_t cur_reg;
  dgptc_chk_t cur_next;

  // Next shadow from register writes
  always_comb begin
    cur_next = cur_reg;
    for (int i = 0; i < 2; i++) begin
      if (cur_reg.age[i] != 3'h7) cur_next.age[i] = cur_reg.age[i] + 3'h1;
      if (reg_write && reg_addr == 8'(i * 32)) begin
        cur_next.pol[i] = reg_wdata[dgptc_pkg::CTRL_OUT_POL];
        cur_next.age[i] = 3'h0;
      end
      if (reg_write && reg_addr == 8'(i * 32 + 4) && (|reg_wdata[1:0])) begin
        cur_next.run[i] = !reg_wdata[dgptc_pkg::CMD_RESET];
        cur_next.age[i] = 3'h0;
      end
    end
    if (reg_write && reg_addr == dgptc_pkg::OFF_IRQ_MASK) cur_next.mask = reg_wdata[1:0];
  end

  // Shadow register
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) cur_reg <= '0;
    else cur_reg <= cur_next;
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  a_out_low_init: assert property ($rose(reset_n) |-> (counter_output == 2'h0) [*2])
    else $error("output not low after reset");
  a_irq_low_init: assert property ($rose(reset_n) |-> (!irq) [*3])
    else $error("irq high after reset");
  a_idle_out_ch0: assert property ((!cur_reg.run[0] && cur_reg.age[0] >= 3'h4) |->
    counter_output[0] == cur_reg.pol[0]) else $error("channel 0 output active while halted");
  a_idle_out_ch1: assert property ((!cur_reg.run[1] && cur_reg.age[1] >= 3'h4) |->
    counter_output[1] == cur_reg.pol[1]) else $error("channel 1 output active while halted");
  a_rdata_one_cycle: assert property ((reg_read ##1 !reg_read) |=> reg_rdata == 32'h0)
    else $error("read data stood too long");
  a_rdata_upper_zero: assert property (reg_rdata[31:16] == 16'h0000)
    else $error("read data above 16 bits");
  a_unmapped_zero: assert property ((reg_read && reg_addr == 8'hFC) |=> reg_rdata == 32'h0)
    else $error("unmapped read not zero");
  a_irq_needs_mask: assert property ($rose(irq) |-> cur_reg.mask != 2'h0)
    else $error("irq rose while masked");

  c_irq_rise: cover property ($rose(irq));
  c_out0_rise: cover property ($rose(counter_output[0]));
  c_out1_fall: cover property ($fell(counter_output[1]));
endmodule : dgptc_sva

bind dgptc_top dgptc_sva dgptc_sva_i (.sys_clk, .reset_n, .reg_addr, .reg_wdata, .reg_write,
  .reg_read, .reg_rdata, .counter_clock_in, .counter_gate_in, .count_direction_in,
  .counter_output, .irq);
`default_nettype wire

// ==== dgptc_top.sv ====
// Dual 16-bit up/down timer/counter with a strobe register port.
// Assumes pins are synchronous to sys_clk and strobes are single cycles.
// Functional notes
// - two independent 16-bit up/down counters
// - internal or external count clock, external max 10MHz
// - each active clock edge steps count by direction; pulse modes always count down
// - clock, gate, output polarity programmable
// - load initial count, read count freely
// - idle until start; soft reset reloads, halts
// - output low after initialization
// - gated counting holds while gate inactive
// - period between gate edges, then output high
// - count during active gate, then output high
// - one delayed pulse after start, gate freezes
// - first gate edge triggers one pulse only
// - each gate edge pulses, busy edges ignored
// - first gate edge starts periodic pulses
// - periodic pulses after start, gate pauses
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// One counter channel
// ****************************************
module dgptc_channel (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Internal count clock enable
  input wire logic int_tick,
  // Configuration
  input wire logic [15:0] ctrl,
  input wire logic [15:0] init_val,
  input wire logic [15:0] delay_val,
  input wire logic [15:0] width_val,
  // Commands, one cycle each
  input wire logic start,
  input wire logic sw_reset,
  // Pins
  input wire logic counter_clock_in,
  input wire logic counter_gate_in,
  input wire logic count_direction_in,
  output logic counter_output,
  // Status
  output logic [15:0] count,
  output logic [5:0] state,
  output logic done_evt
);

  // Channel state record
  typedef struct packed {
    dgptc_pkg::dgptc_state_t st; // Sequence state
    logic [15:0] cnt; // Count or phase counter
    logic clk_prev; // Previous active-high clock level
    logic gate_prev; // Previous active-high gate level
    logic out_act; // Output active
    logic out_pin; // Output pin level
    logic done; // End-of-operation pulse
  } dgptc_ch_t;

  dgptc_ch_t ch_reg; // Registered state
  dgptc_ch_t ch_next; // Next state

  // Decoded configuration
  dgptc_pkg::dgptc_mode_t mode; // Selected mode
  logic clk_lvl; // Clock level, active high
  logic clk_edge; // One active count edge
  logic gate_lvl; // Gate level, active high
  logic gate_edge; // Gate turned active
  logic cnt_up; // Count direction
  logic gated; // Mode freezes on inactive gate
  logic advance; // Phase counter may step
  logic [15:0] step_val; // Count after one step

  // ****************************************
  // Input conditioning
  // ****************************************
  always_comb begin
    mode = dgptc_pkg::dgptc_mode_t'(ctrl[dgptc_pkg::CTRL_MODE_LSB +: 3]);
    // Polarity folded in so all later logic is active high
    clk_lvl = counter_clock_in ^ ctrl[dgptc_pkg::CTRL_CLK_POL];
    gate_lvl = ctrl[dgptc_pkg::CTRL_GATE_SRC] ?
               (counter_gate_in ^ ctrl[dgptc_pkg::CTRL_GATE_POL]) :
               ctrl[dgptc_pkg::CTRL_GATE_SW];
    // External pin edge or internal divider tick
    clk_edge = ctrl[dgptc_pkg::CTRL_CLK_SRC] ? (clk_lvl & ~ch_reg.clk_prev) : int_tick;
    gate_edge = gate_lvl & ~ch_reg.gate_prev;
    cnt_up = ctrl[dgptc_pkg::CTRL_DIR_SRC] ? count_direction_in :
             ctrl[dgptc_pkg::CTRL_DIR_SW];
    step_val = cnt_up ? (ch_reg.cnt + 16'h0001) : (ch_reg.cnt - 16'h0001);
    gated = (mode == dgptc_pkg::MODE_GATED_PULSE) || (mode == dgptc_pkg::MODE_GATED_CONT);
    advance = clk_edge & (gate_lvl | ~gated);
  end

  // ****************************************
  // Sequencer
  // ****************************************
  always_comb begin
    ch_next = ch_reg;
    ch_next.done = 1'b0;
    ch_next.clk_prev = clk_lvl;
    ch_next.gate_prev = gate_lvl;
    if (sw_reset) begin
      // Soft reset: halt, clear status, reload
      ch_next.st = dgptc_pkg::ST_IDLE;
      ch_next.cnt = init_val;
      ch_next.out_act = 1'b0;
    end else if (start) begin
      // Start re-arms from any state
      ch_next.out_act = 1'b0;
      case (mode)
        dgptc_pkg::MODE_GATED_CNT: ch_next.st = dgptc_pkg::ST_RUN;
        dgptc_pkg::MODE_PERIOD, dgptc_pkg::MODE_PWIDTH: begin
          ch_next.st = dgptc_pkg::ST_ARM;
          ch_next.cnt = init_val;
        end
        dgptc_pkg::MODE_GATED_PULSE, dgptc_pkg::MODE_GATED_CONT: begin
          ch_next.st = dgptc_pkg::ST_DELAY;
          ch_next.cnt = delay_val;
        end
        default: ch_next.st = dgptc_pkg::ST_ARM; // Wait for trigger
      endcase
    end else begin
      case (ch_reg.st)
        dgptc_pkg::ST_IDLE: begin
          // Halted until software start
        end
        dgptc_pkg::ST_ARM: begin
          if (gate_edge) begin
            if ((mode == dgptc_pkg::MODE_PERIOD) || (mode == dgptc_pkg::MODE_PWIDTH)) begin
              ch_next.st = dgptc_pkg::ST_RUN;
            end else begin
              ch_next.st = dgptc_pkg::ST_DELAY;
              ch_next.cnt = delay_val;
            end
          end
        end
        dgptc_pkg::ST_RUN: begin
          case (mode)
            dgptc_pkg::MODE_PERIOD: begin
              if (gate_edge) begin
                // Second gate edge closes the period
                ch_next.st = dgptc_pkg::ST_DONE;
                ch_next.out_act = 1'b1;
                ch_next.done = 1'b1;
              end else if (clk_edge) begin
                ch_next.cnt = step_val;
              end
            end
            dgptc_pkg::MODE_PWIDTH: begin
              if (!gate_lvl) begin
                // Gate went inactive: width complete
                ch_next.st = dgptc_pkg::ST_DONE;
                ch_next.out_act = 1'b1;
                ch_next.done = 1'b1;
              end else if (clk_edge) begin
                ch_next.cnt = step_val;
              end
            end
            default: begin
              // Gated event counting, value held while gate inactive
              if (clk_edge && gate_lvl) begin
                ch_next.cnt = step_val;
              end
            end
          endcase
        end
        dgptc_pkg::ST_DELAY: begin
          // Output inactive for the delay count
          if ((ch_reg.cnt == 16'h0000) || (advance && (ch_reg.cnt == 16'h0001))) begin
            ch_next.st = dgptc_pkg::ST_PULSE;
            ch_next.out_act = 1'b1;
            ch_next.cnt = width_val;
          end else if (advance) begin
            ch_next.cnt = ch_reg.cnt - 16'h0001;
          end
        end
        dgptc_pkg::ST_PULSE: begin
          // Output active for the width count
          if ((ch_reg.cnt == 16'h0000) || (advance && (ch_reg.cnt == 16'h0001))) begin
            ch_next.out_act = 1'b0;
            ch_next.done = 1'b1;
            case (mode)
              dgptc_pkg::MODE_RETRIG: ch_next.st = dgptc_pkg::ST_ARM;
              dgptc_pkg::MODE_TRIG_CONT, dgptc_pkg::MODE_GATED_CONT: begin
                ch_next.st = dgptc_pkg::ST_DELAY;
                ch_next.cnt = delay_val;
              end
              default: ch_next.st = dgptc_pkg::ST_DONE;
            endcase
          end else if (advance) begin
            ch_next.cnt = ch_reg.cnt - 16'h0001;
          end
        end
        dgptc_pkg::ST_DONE: begin
          // Result held for software, gate ignored
        end
        default: ch_next.st = dgptc_pkg::ST_IDLE; // Illegal code recovery
      endcase
    end
    // Pin level after polarity
    ch_next.out_pin = ch_next.out_act ^ ctrl[dgptc_pkg::CTRL_OUT_POL];
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ch_reg <= '{st: dgptc_pkg::ST_IDLE, cnt: dgptc_pkg::CNT_RST, clk_prev: 1'b0,
                  gate_prev: 1'b0, out_act: 1'b0, out_pin: 1'b0, done: 1'b0};
    end else begin
      ch_reg <= ch_next;
    end
  end

  // Outputs straight from the state register
  assign counter_output = ch_reg.out_pin;
  assign count = ch_reg.cnt;
  assign state = ch_reg.st;
  assign done_evt = ch_reg.done;

endmodule : dgptc_channel

// ****************************************
// Top: register port, interrupts, two channels
// ****************************************
module dgptc_top (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  // Counter pins, one bit per channel
  input wire logic [1:0] counter_clock_in,
  input wire logic [1:0] counter_gate_in,
  input wire logic [1:0] count_direction_in,
  output logic [1:0] counter_output,
  // Interrupt
  output logic irq
);

  // Top state record
  typedef struct packed {
    logic [1:0][15:0] ctrl; // Configuration per channel
    logic [1:0][15:0] init; // Initial count per channel
    logic [1:0][15:0] delay; // Delay or interval per channel
    logic [1:0][15:0] width; // Pulse width per channel
    logic [1:0] start; // Start strobes
    logic [1:0] sw_rst; // Soft reset strobes
    logic [1:0] irq_stat; // Sticky done events
    logic [1:0] irq_mask; // Event enables
    logic [7:0] div; // Internal clock divider
    logic tick; // Internal count clock enable
    logic [31:0] rdata; // Read data
    logic irq; // Interrupt level
  } dgptc_top_t;

  dgptc_top_t top_reg; // Registered state
  dgptc_top_t top_next; // Next state

  logic [1:0][15:0] ch_count; // Present counts
  logic [1:0][5:0] ch_state; // Channel states
  logic [1:0] ch_done; // Done pulses
  logic ch_sel; // Addressed channel
  logic ch_hit; // Address in channel window
  logic [4:0] ch_off; // Offset within channel

  // ****************************************
  // Channels
  // ****************************************
  for (genvar i = 0; i < 2; i++) begin : g_ch
    dgptc_channel dgptc_channel_i (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .int_tick(top_reg.tick),
      .ctrl(top_reg.ctrl[i]),
      .init_val(top_reg.init[i]),
      .delay_val(top_reg.delay[i]),
      .width_val(top_reg.width[i]),
      .start(top_reg.start[i]),
      .sw_reset(top_reg.sw_rst[i]),
      .counter_clock_in(counter_clock_in[i]),
      .counter_gate_in(counter_gate_in[i]),
      .count_direction_in(count_direction_in[i]),
      .counter_output(counter_output[i]),
      .count(ch_count[i]),
      .state(ch_state[i]),
      .done_evt(ch_done[i])
    );
  end

  // ****************************************
  // Decode, registers, divider, interrupts
  // ****************************************
  always_comb begin
    top_next = top_reg;
    ch_sel = reg_addr[5];
    ch_hit = (reg_addr[7:6] == 2'h0);
    ch_off = reg_addr[4:0];
    top_next.start = 2'h0;
    top_next.sw_rst = 2'h0;
    // Internal count clock enable
    if (top_reg.div >= (dgptc_pkg::INT_DIV_CYC - 8'h01)) begin
      top_next.div = 8'h00;
      top_next.tick = 1'b1;
    end else begin
      top_next.div = top_reg.div + 8'h01;
      top_next.tick = 1'b0;
    end
    // Register writes
    if (reg_write) begin
      if (ch_hit) begin
        case (ch_off)
          dgptc_pkg::OFF_CTRL: top_next.ctrl[ch_sel] = reg_wdata[15:0];
          dgptc_pkg::OFF_CMD: begin
            top_next.start[ch_sel] = reg_wdata[dgptc_pkg::CMD_START];
            top_next.sw_rst[ch_sel] = reg_wdata[dgptc_pkg::CMD_RESET];
          end
          dgptc_pkg::OFF_INIT: top_next.init[ch_sel] = reg_wdata[15:0];
          dgptc_pkg::OFF_DELAY: top_next.delay[ch_sel] = reg_wdata[15:0];
          dgptc_pkg::OFF_WIDTH: top_next.width[ch_sel] = reg_wdata[15:0];
          default: begin
            // Read-only or unmapped: ignored
          end
        endcase
      end else if (reg_addr == dgptc_pkg::OFF_IRQ_STAT) begin
        top_next.irq_stat = top_reg.irq_stat & ~reg_wdata[1:0];
      end else if (reg_addr == dgptc_pkg::OFF_IRQ_MASK) begin
        top_next.irq_mask = reg_wdata[1:0];
      end
    end
    // New events win over a clear in the same cycle
    top_next.irq_stat = top_next.irq_stat | ch_done;
    top_next.irq = |(top_next.irq_stat & top_next.irq_mask);
    // Read data valid only in the cycle after the strobe
    top_next.rdata = 32'h0000_0000;
    if (reg_read) begin
      if (ch_hit) begin
        case (ch_off)
          dgptc_pkg::OFF_CTRL: top_next.rdata = {16'h0000, top_reg.ctrl[ch_sel]};
          dgptc_pkg::OFF_INIT: top_next.rdata = {16'h0000, top_reg.init[ch_sel]};
          dgptc_pkg::OFF_DELAY: top_next.rdata = {16'h0000, top_reg.delay[ch_sel]};
          dgptc_pkg::OFF_WIDTH: top_next.rdata = {16'h0000, top_reg.width[ch_sel]};
          dgptc_pkg::OFF_COUNT: top_next.rdata = {16'h0000, ch_count[ch_sel]};
          dgptc_pkg::OFF_STAT: begin
            top_next.rdata = {26'h0, ch_state[ch_sel]};
            top_next.rdata[dgptc_pkg::STAT_OUT] = counter_output[ch_sel];
          end
          default: top_next.rdata = 32'h0000_0000; // Command and holes
        endcase
      end else if (reg_addr == dgptc_pkg::OFF_IRQ_STAT) begin
        top_next.rdata = {30'h0, top_reg.irq_stat};
      end else if (reg_addr == dgptc_pkg::OFF_IRQ_MASK) begin
        top_next.rdata = {30'h0, top_reg.irq_mask};
      end
    end
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      top_reg <= '{ctrl: {2{dgptc_pkg::CTRL_RST}}, init: {2{dgptc_pkg::CNT_RST}},
                   delay: {2{dgptc_pkg::CNT_RST}}, width: {2{dgptc_pkg::CNT_RST}},
                   start: 2'h0, sw_rst: 2'h0, irq_stat: dgptc_pkg::IRQ_RST,
                   irq_mask: dgptc_pkg::IRQ_RST, div: 8'h00, tick: 1'b0,
                   rdata: 32'h0000_0000, irq: 1'b0};
    end else begin
      top_reg <= top_next;
    end
  end

  // Outputs from registers
  assign reg_rdata = top_reg.rdata;
  assign irq = top_reg.irq;

endmodule : dgptc_top

`default_nettype wire

// ==== dgptc_top_tb.sv ====
// Self-checking bench for the dual timer/counter.
// Assumes the package register map and the pin source model.
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Bench top
// ****************************************
module dgptc_top_tb;
  logic sys_clk; // 20 MHz clock
  logic reset_n; // Active low reset
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_write;
  logic reg_read;
  logic [31:0] reg_rdata;
  logic [1:0] clk_pin;
  logic [1:0] gate_pin;
  logic [1:0] dir_pin;
  logic [1:0] out_pin;
  logic irq;
  int fail_count;
  int num_checks;

  dgptc_top dgptc_top_i (.sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .counter_clock_in(clk_pin), .counter_gate_in(gate_pin), .count_direction_in(dir_pin),
    .counter_output(out_pin), .irq(irq));
  dgptc_partner dgptc_partner_i (.sys_clk(sys_clk), .counter_clock_in(clk_pin),
    .counter_gate_in(gate_pin), .count_direction_in(dir_pin));

  // Clock, 50 ns period
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  // Closing report
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : give_verdict

  task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", w, e, g);
    end
  endtask : chk

  // One-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge sys_clk);
    reg_write <= 1'b0;
  endtask : wr

  // One-cycle read, data taken the cycle after
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string w);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge sys_clk);
    reg_read <= 1'b0;
    #1;
    chk(w, e, reg_rdata);
  endtask : rd_chk

  // Reset values, read-only and unmapped places
  task automatic t_reset();
    chk("out", 32'h0, 32'(out_pin));
    rd_chk(8'h00, 32'h0, "ctrl0");
    rd_chk(8'h38, 32'(dgptc_pkg::ST_IDLE), "stat1");
    rd_chk(8'hFC, 32'h0, "unmapped");
    wr(8'h28, 32'h0000ABCD);
    rd_chk(8'h28, 32'h0000ABCD, "init1");
    wr(8'h14, 32'h00001234);
    rd_chk(8'h14, 32'h0, "count ro");
  endtask : t_reset

  // Gated counting on channel 0, falling clock, gate active low, pin direction
  task automatic t_gated();
    wr(8'h00, 32'h00000178);
    wr(8'h08, 32'h5);
    wr(8'h04, 32'h2);
    dgptc_partner_i.pins(0, 1'b0, 1'b0);
    wr(8'h04, 32'h1);
    dgptc_partner_i.pulses(0, 3);
    rd_chk(8'h14, 32'h2, "count down");
    dgptc_partner_i.pins(0, 1'b1, 1'b1);
    dgptc_partner_i.pulses(0, 2);
    rd_chk(8'h14, 32'h2, "count held");
    dgptc_partner_i.pins(0, 1'b0, 1'b1);
    dgptc_partner_i.pulses(0, 1);
    rd_chk(8'h14, 32'h3, "count up");
    rd_chk(8'h34, 32'h0, "count1 alone");
    wr(8'h04, 32'h2);
    rd_chk(8'h14, 32'h5, "count reload");
    dgptc_partner_i.pulses(0, 2);
    rd_chk(8'h14, 32'h5, "count halted");
  endtask : t_gated

  // Period or width measurement on channel 1
  task automatic t_meas(input logic [2:0] m, input logic [31:0] e);
    int n;
    n = 0;
    wr(8'h20, 32'h00000228 | 32'(m));
    wr(8'h28, 32'h0);
    wr(8'h24, 32'h2);
    dgptc_partner_i.pins(1, 1'b0, 1'b1);
    wr(8'h24, 32'h1);
    dgptc_partner_i.pins(1, 1'b1, 1'b1);
    dgptc_partner_i.pulses(1, 3);
    dgptc_partner_i.pins(1, 1'b0, 1'b1);
    dgptc_partner_i.pulses(1, 2);
    dgptc_partner_i.pins(1, 1'b1, 1'b1);
    while (out_pin[1] !== 1'b1 && n < 50) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    chk("meas out", 32'h1, 32'(out_pin[1]));
    rd_chk(8'h34, e, "meas count");
  endtask : t_meas

  // Single gated pulse: delay 2, width 4 internal ticks, then interrupt
  task automatic t_pulse(input int ch, input logic pol);
    logic [7:0] b;
    int n;
    b = 8'(ch * 32);
    wr(b, 32'h00000083 | (32'(pol) << 10));
    wr(b + 8'h0C, 32'h2);
    wr(b + 8'h10, 32'h4);
    wr(8'h40, 32'h3);
    wr(8'h44, 32'(1 << ch));
    wr(b + 8'h04, 32'h2);
    repeat (4) @(posedge sys_clk);
    #1;
    chk("idle level", 32'(pol), 32'(out_pin[ch]));
    wr(b + 8'h04, 32'h1);
    n = 0;
    while (out_pin[ch] === pol && n < 100) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    chk("delay", 32'h1, 32'(n >= 2 * dgptc_pkg::INT_DIV_CYC && n <= 3 * dgptc_pkg::INT_DIV_CYC));
    n = 0;
    while (out_pin[ch] === !pol && n < 100) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    chk("width", 32'(4 * dgptc_pkg::INT_DIV_CYC), 32'(n));
    repeat (3) @(posedge sys_clk);
    #1;
    chk("irq set", 32'h1, 32'(irq));
    rd_chk(8'h40, 32'(1 << ch), "irq stat");
    wr(8'h40, 32'(1 << ch));
    repeat (2) @(posedge sys_clk);
    #1;
    chk("irq clear", 32'h0, 32'(irq));
    rd_chk(b + 8'h18, 32'(dgptc_pkg::ST_DONE) | (32'(pol) << 8), "stat done");
  endtask : t_pulse

  // Gate-triggered and gated pulse modes on channel 0; counts output pulses
  task automatic t_trig(input logic [2:0] m, input int lo, input int hi);
    int n;
    logic prev;
    n = 0;
    prev = 1'b0;
    wr(8'h00, 32'h00000020 | 32'(m));
    wr(8'h04, 32'h2);
    dgptc_partner_i.pins(0, 1'b0, 1'b0);
    wr(8'h04, 32'h1);
    for (int c = 0; c < 150; c++) begin
      if (c == 5 || c == 14 || c == 60) dgptc_partner_i.pins(0, 1'b1, 1'b0);
      else if (c == 12 || c == 20 || c == 70) dgptc_partner_i.pins(0, 1'b0, 1'b0);
      else @(posedge sys_clk);
      #1;
      if (out_pin[0] === 1'b1 && prev !== 1'b1) n++;
      prev = out_pin[0];
    end
    chk("pulse count in range", 32'h1, 32'(n >= lo && n <= hi));
  endtask : t_trig

  // Main sequence
  initial begin
    reset_n = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_write = 1'b0;
    reg_read = 1'b0;
    fail_count = 0;
    num_checks = 0;
    repeat (6) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    #1;
    t_reset();
    t_gated();
    t_meas(3'h1, 32'h5);
    t_meas(3'h2, 32'h3);
    t_pulse(0, 1'b0);
    t_pulse(1, 1'b1);
    t_trig(3'h4, 1, 1);
    t_trig(3'h5, 2, 2);
    t_trig(3'h6, 8, 14);
    t_trig(3'h7, 1, 4);
    give_verdict();
  end
endmodule : dgptc_top_tb
`default_nettype wire
